// *** bsls_pkg.sv ***
package bsls_pkg;
   // ------------------------------
   // register map, byte offsets
   // ------------------------------
   localparam logic [7:0] OFS_INSTR = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_FLAGS = 8'h08;
   localparam logic [7:0] OFS_PC = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam int GPR_WIN_BIT = 7;
   localparam int CTRL_LONG_BIT = 0;
   localparam int ST_TAKEN_BIT = 2;
   localparam int ST_BAD_BIT = 3;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // ------------------------------
   // reset values
   // ------------------------------
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [31:0] INSTR_RST = 32'h0000_0000;

   // ------------------------------
   // flag positions in flags_word
   // ------------------------------
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam logic [2:0] FLG_S = 3'h4;

   // ------------------------------
   // pointer pairs, low register index
   // ------------------------------
   localparam logic [4:0] PTR_X = 5'h1a;
   localparam logic [4:0] PTR_Y = 5'h1c;
   localparam logic [4:0] PTR_Z = 5'h1e;

   // ------------------------------
   // cycle counts
   // ------------------------------
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_BR_TAKEN = 2'h2;
   localparam logic [1:0] CYC_MEM = 2'h2;
   localparam logic [1:0] CYC_SKIP_SHORT = 2'h2;
   localparam logic [1:0] CYC_SKIP_LONG = 2'h3;

   typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_REST} bsls_state_e;
   typedef enum logic [3:0] {
      OP_NONE, OP_COPY, OP_PAIR, OP_IMM, OP_SKIP_REG, OP_SKIP_IO,
      OP_BRANCH, OP_PTR, OP_DISP, OP_ABS
   } bsls_op_e;
endpackage : bsls_pkg

// *** bsls_exec.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - register bit skip: on clear/set form, pc advances 2 or 3, 1-3 cycles
// RL2 - io register bit skip behaves the same, 1-3 cycles
// RL3 - generic flag branch tests flags_word bit s, n xor v for s=4; taken: pc+k+1, 2 cycles, else 1
// RL4 - equal/unequal branches follow the zero flag
// RL5 - carry high / unsigned lt on carry 1; carry low / unsigned ge on carry 0
// RL6 - negative branch on n=1, positive branch on n=0
// RL7 - signed ge when n xor v is 0, signed less when it is 1
// RL8 - half carry branches follow the half carry flag
// RL9 - transfer bit branches follow the t flag
// RL10 - irq on/off branches follow the global interrupt enable flag
// RL11 - pointer read loads byte at pointer; post-increment adds 1; 2 cycles
// RL12 - pre-decrement read subtracts 1 first, then reads; 2 cycles
// RL13 - offset pointer read uses pointer plus q, pointer kept; 2 cycles
// RL14 - absolute read loads byte at address k; 2 cycles
// RL15 - pointer write stores Rr at pointer; post-increment adds 1; 2 cycles
// RL16 - pre-decrement write subtracts 1 first, then stores; 2 cycles
// RL17 - offset pointer write stores at pointer plus q, pointer kept; 2 cycles
// RL18 - register copy, pair copy and immediate load take one cycle
// RL19 - none of these instructions alter any flag
module bsls_exec (
   input logic hclk,
   input logic hresetn,
   input logic ce,
   input logic hsel,
   input logic [31:0] haddr,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic [2:0] hsize,
   input logic [31:0] hwdata,
   input logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [15:0] dmem_addr,
   output logic [7:0] dmem_wdata,
   output logic dmem_re,
   output logic dmem_we,
   input logic [7:0] dmem_rdata,
   output logic [4:0] io_addr,
   input logic [7:0] io_rdata
);
   // ------------------------------
   // helpers
   // ------------------------------
   function automatic bsls_pkg::bsls_op_e op_decode(input logic [15:0] w);
      casez (w)
         16'b0010_11??_????_????: op_decode = bsls_pkg::OP_COPY;
         16'b0000_0001_????_????: op_decode = bsls_pkg::OP_PAIR;
         16'b1110_????_????_????: op_decode = bsls_pkg::OP_IMM;
         16'b1111_11??_????_0???: op_decode = bsls_pkg::OP_SKIP_REG;
         16'b1001_10?1_????_????: op_decode = bsls_pkg::OP_SKIP_IO;
         16'b1111_0???_????_????: op_decode = bsls_pkg::OP_BRANCH;
         16'b10?0_????_????_????: op_decode = bsls_pkg::OP_DISP;
         default: op_decode = bsls_pkg::OP_NONE;
      endcase
      // pointer and absolute forms, picked by the low nibble
      if ((w[15:12] == 4'h9) && (w[11:10] == 2'h0)) begin
         case (w[3:0])
            4'h0: op_decode = w[9] ? bsls_pkg::OP_NONE : bsls_pkg::OP_ABS;
            4'h1, 4'h2, 4'h9, 4'ha, 4'hc, 4'hd, 4'he: op_decode = bsls_pkg::OP_PTR;
            default: op_decode = bsls_pkg::OP_NONE;
         endcase
      end
   endfunction : op_decode

   // signed flag is derived from n xor v, not the stored bit
   function automatic logic flag_test(input logic [7:0] f, input logic [2:0] s);
      if (s == bsls_pkg::FLG_S) begin
         flag_test = f[bsls_pkg::FLG_N] ^ f[bsls_pkg::FLG_V]; // RL7
      end else begin
         flag_test = f[s];
      end
   endfunction : flag_test

   function automatic logic [4:0] ptr_sel(input logic [15:0] w, input logic disp);
      if (disp) begin
         ptr_sel = w[3] ? bsls_pkg::PTR_Y : bsls_pkg::PTR_Z;
      end else begin
         case (w[3:2])
            2'h3: ptr_sel = bsls_pkg::PTR_X;
            2'h2: ptr_sel = bsls_pkg::PTR_Y;
            default: ptr_sel = bsls_pkg::PTR_Z;
         endcase
      end
   endfunction : ptr_sel

   // ------------------------------
   // state
   // ------------------------------
   bsls_pkg::bsls_state_e st, next_st;
   bsls_pkg::bsls_op_e op;
   logic [1:0] cnt, next_cnt, last_cyc, next_last_cyc, step;
   logic [31:0] instr, next_instr;
   logic [7:0] flags, next_flags, next_dmem_wdata;
   logic [15:0] pc, next_pc, next_dmem_addr, ptr, ea, pnew;
   logic [7:0] gpr [32];
   logic [7:0] next_gpr [32];
   logic [4:0] dst, next_dst, next_io_addr, rd, pidx;
   logic ctrl_long, next_ctrl_long, taken, next_taken, bad, next_bad;
   logic next_dmem_re, next_dmem_we, pupd, hit;

   logic dph, next_dph, a_write, next_a_write, a_ok, next_a_ok;
   logic next_hreadyout, acc, act;
   logic [7:0] a_addr, next_a_addr;
   logic [31:0] next_hrdata, rmux;

   // ------------------------------
   // ahb-lite slave
   // ------------------------------
   always_comb begin
      acc = hsel && htrans[1] && hready;
      act = dph && (st == bsls_pkg::ST_IDLE);
      next_dph = dph ? !act : acc;
      next_hreadyout = dph ? act : !acc;
      next_a_addr = acc ? haddr[7:0] : a_addr;
      next_a_write = acc ? hwrite : a_write;
      next_a_ok = acc ? ((haddr[31:8] == 24'h00_0000) && (hsize == bsls_pkg::HSIZE_WORD))
                      : a_ok;
      rmux = 32'h0000_0000;
      if (!a_ok) begin
         rmux = 32'h0000_0000;
      end else if (a_addr[bsls_pkg::GPR_WIN_BIT]) begin
         rmux[7:0] = gpr[a_addr[6:2]];
      end else begin
         case (a_addr)
            bsls_pkg::OFS_INSTR: rmux = instr;
            bsls_pkg::OFS_CTRL: rmux[bsls_pkg::CTRL_LONG_BIT] = ctrl_long;
            bsls_pkg::OFS_FLAGS: rmux[7:0] = flags;
            bsls_pkg::OFS_PC: rmux[15:0] = pc;
            bsls_pkg::OFS_STATUS: begin
               rmux[1:0] = last_cyc;
               rmux[bsls_pkg::ST_TAKEN_BIT] = taken;
               rmux[bsls_pkg::ST_BAD_BIT] = bad;
            end
            default: rmux = 32'h0000_0000;
         endcase
      end
      next_hrdata = (act && !a_write) ? rmux : hrdata;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph <= 1'b0;
         a_addr <= 8'h00;
         a_write <= 1'b0;
         a_ok <= 1'b0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         dph <= next_dph;
         a_addr <= next_a_addr;
         a_write <= next_a_write;
         a_ok <= next_a_ok;
         hrdata <= next_hrdata;
         hreadyout <= next_hreadyout;
         hresp <= 1'b0;
      end
   end

   // ------------------------------
   // execution
   // ------------------------------
   always_comb begin
      next_st = st;
      next_cnt = cnt;
      next_instr = instr;
      next_ctrl_long = ctrl_long;
      next_flags = flags;
      next_pc = pc;
      next_gpr = gpr;
      next_last_cyc = last_cyc;
      next_taken = taken;
      next_bad = bad;
      next_dst = dst;
      next_dmem_addr = dmem_addr;
      next_dmem_wdata = dmem_wdata;
      next_dmem_re = 1'b0;
      next_dmem_we = 1'b0;
      next_io_addr = io_addr;
      op = op_decode(instr[15:0]);
      rd = instr[8:4];
      pidx = ptr_sel(instr[15:0], op == bsls_pkg::OP_DISP);
      ptr = {gpr[pidx + 5'h01], gpr[pidx]};
      ea = ptr;
      pnew = ptr;
      pupd = 1'b0;
      hit = 1'b0;
      step = bsls_pkg::CYC_ONE;
      case (st)
         bsls_pkg::ST_IDLE: begin
            if (act && a_write && a_ok) begin
               if (a_addr[bsls_pkg::GPR_WIN_BIT]) begin
                  next_gpr[a_addr[6:2]] = hwdata[7:0];
               end else begin
                  case (a_addr)
                     bsls_pkg::OFS_INSTR: begin
                        next_instr = hwdata;
                        next_io_addr = hwdata[7:3];
                        next_st = bsls_pkg::ST_FIRST;
                     end
                     bsls_pkg::OFS_CTRL: next_ctrl_long = hwdata[bsls_pkg::CTRL_LONG_BIT];
                     bsls_pkg::OFS_FLAGS: next_flags = hwdata[7:0];
                     bsls_pkg::OFS_PC: next_pc = hwdata[15:0];
                     default: next_st = bsls_pkg::ST_IDLE;
                  endcase
               end
            end
         end
         bsls_pkg::ST_FIRST: begin
            // flags_word stays untouched by every form below
            next_flags = flags; // RL19
            next_pc = pc + 16'h0001;
            next_taken = 1'b0;
            next_bad = 1'b0;
            case (op)
               bsls_pkg::OP_COPY: next_gpr[rd] = gpr[{instr[9], instr[3:0]}]; // RL18
               bsls_pkg::OP_PAIR: begin
                  next_gpr[{instr[7:4], 1'b0}] = gpr[{instr[3:0], 1'b0}]; // RL18
                  next_gpr[{instr[7:4], 1'b1}] = gpr[{instr[3:0], 1'b1}]; // RL18
               end
               bsls_pkg::OP_IMM: next_gpr[{1'b1, instr[7:4]}] = {instr[11:8], instr[3:0]}; // RL18
               bsls_pkg::OP_SKIP_REG, bsls_pkg::OP_SKIP_IO: begin
                  if (op == bsls_pkg::OP_SKIP_REG) begin
                     hit = gpr[rd][instr[2:0]] == instr[9]; // RL1
                  end else begin
                     hit = io_rdata[instr[2:0]] == instr[9]; // RL2
                  end
                  if (hit) begin
                     step = ctrl_long ? bsls_pkg::CYC_SKIP_LONG : bsls_pkg::CYC_SKIP_SHORT;
                     next_pc = pc + {14'h0000, step}; // RL1 RL2
                  end
                  next_taken = hit;
               end
               bsls_pkg::OP_BRANCH: begin
                  hit = flag_test(flags, instr[2:0]) ^ instr[10]; // RL3 RL4 RL5 RL6 RL8 RL9 RL10
                  if (hit) begin
                     step = bsls_pkg::CYC_BR_TAKEN; // RL3
                     next_pc = pc + {{9{instr[9]}}, instr[9:3]} + 16'h0001; // RL3
                  end
                  next_taken = hit;
               end
               bsls_pkg::OP_PTR, bsls_pkg::OP_DISP, bsls_pkg::OP_ABS: begin
                  if (op == bsls_pkg::OP_ABS) begin
                     ea = instr[31:16]; // RL14
                     next_pc = pc + 16'h0002;
                  end else if (op == bsls_pkg::OP_DISP) begin
                     ea = ptr + {10'h000, instr[13], instr[11:10], instr[2:0]}; // RL13 RL17
                  end else if (instr[1:0] == 2'h2) begin
                     pnew = ptr - 16'h0001; // RL12 RL16
                     ea = pnew;
                     pupd = 1'b1;
                  end else if (instr[1:0] == 2'h1) begin
                     pnew = ptr + 16'h0001; // RL11 RL15
                     pupd = 1'b1;
                  end
                  if (pupd) begin
                     next_gpr[pidx] = pnew[7:0];
                     next_gpr[pidx + 5'h01] = pnew[15:8];
                  end
                  next_dmem_addr = ea;
                  step = bsls_pkg::CYC_MEM; // RL11 RL12 RL13 RL14 RL15 RL16 RL17
                  if (instr[9]) begin
                     next_dmem_we = 1'b1; // RL15 RL16 RL17
                     next_dmem_wdata = gpr[rd];
                  end else begin
                     next_dmem_re = 1'b1; // RL11 RL12 RL13 RL14
                     next_dst = rd;
                  end
               end
               default: next_bad = 1'b1;
            endcase
            next_last_cyc = step;
            next_cnt = step - 2'h1;
            next_st = (step == bsls_pkg::CYC_ONE) ? bsls_pkg::ST_IDLE : bsls_pkg::ST_REST;
         end
         bsls_pkg::ST_REST: begin
            // read data stands while the read strobe is high
            if (dmem_re) begin
               next_gpr[dst] = dmem_rdata; // RL11 RL12 RL13 RL14
            end
            next_cnt = cnt - 2'h1;
            if (cnt == 2'h1) begin
               next_st = bsls_pkg::ST_IDLE;
            end
         end
         default: next_st = bsls_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= bsls_pkg::ST_IDLE;
         cnt <= 2'h0;
         instr <= bsls_pkg::INSTR_RST;
         ctrl_long <= 1'b0;
         flags <= bsls_pkg::FLAGS_RST;
         pc <= bsls_pkg::PC_RST;
         gpr <= '{default: 8'h00};
         last_cyc <= 2'h0;
         taken <= 1'b0;
         bad <= 1'b0;
         dst <= 5'h00;
         dmem_addr <= 16'h0000;
         dmem_wdata <= 8'h00;
         dmem_re <= 1'b0;
         dmem_we <= 1'b0;
         io_addr <= 5'h00;
      end else if (ce) begin
         st <= next_st;
         cnt <= next_cnt;
         instr <= next_instr;
         ctrl_long <= next_ctrl_long;
         flags <= next_flags;
         pc <= next_pc;
         gpr <= next_gpr;
         last_cyc <= next_last_cyc;
         taken <= next_taken;
         bad <= next_bad;
         dst <= next_dst;
         dmem_addr <= next_dmem_addr;
         dmem_wdata <= next_dmem_wdata;
         dmem_re <= next_dmem_re;
         dmem_we <= next_dmem_we;
         io_addr <= next_io_addr;
      end
   end
endmodule : bsls_exec

// *** bsls_dmem_model.sv ***
`timescale 1ns/1ps
module bsls_dmem_model (
   input logic hclk,
   input logic [15:0] dmem_addr,
   input logic [7:0] dmem_wdata,
   input logic dmem_re,
   input logic dmem_we,
   output logic [7:0] dmem_rdata,
   input logic [4:0] io_addr,
   output logic [7:0] io_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'h00;
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'h3c;
   end
   always @(posedge hclk) begin
      if (dmem_we) mem[dmem_addr] <= dmem_wdata;
      if (dmem_re) last <= mem[dmem_addr];
   end
   // idle bus shows the inverse of the last byte
   assign dmem_rdata = dmem_re ? mem[dmem_addr] : ~last;
   // io register n holds n in bits 7:3 and 101 below
   assign io_rdata = {io_addr, 3'b101};
endmodule : bsls_dmem_model

// *** bsls_exec_asserts.sv ***
`timescale 1ns/1ps
module bsls_exec_asserts (
   input logic hclk,
   input logic hresetn,
   input logic hsel,
   input logic [1:0] htrans,
   input logic hready,
   input logic [31:0] hrdata,
   input logic hreadyout,
   input logic hresp,
   input logic [15:0] dmem_addr,
   input logic [7:0] dmem_wdata,
   input logic dmem_re,
   input logic dmem_we
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   logic taken;
   assign taken = hsel && htrans[1] && hready;
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_stall; taken |=> !hreadyout; endproperty
   a_stall: assert property (p_stall) else $error("no wait state");
   property p_answer; taken |=> !hreadyout ##[1:6] hreadyout; endproperty
   a_answer: assert property (p_answer) else $error("bus answer late");
   property p_rd; dmem_re |=> !dmem_re; endproperty
   a_rd: assert property (p_rd) else $error("read strobe too long");
   property p_wr; dmem_we |=> !dmem_we; endproperty
   a_wr: assert property (p_wr) else $error("write strobe too long");
   property p_excl; !(dmem_re && dmem_we); endproperty
   a_excl: assert property (p_excl) else $error("read and write together");
   property p_addr; $changed(dmem_addr) |-> dmem_re || dmem_we; endproperty
   a_addr: assert property (p_addr) else $error("address moved alone");
   property p_wdat; $changed(dmem_wdata) |-> dmem_we; endproperty
   a_wdat: assert property (p_wdat) else $error("store data moved alone");
   property p_rdat; $changed(hrdata) |-> $past(hreadyout) == 1'b0; endproperty
   a_rdat: assert property (p_rdat) else $error("read data moved early");
endmodule : bsls_exec_asserts
bind bsls_exec bsls_exec_asserts u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dmem_addr(dmem_addr),
   .dmem_wdata(dmem_wdata), .dmem_re(dmem_re), .dmem_we(dmem_we)
);

// *** tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = bsls_pkg::HSIZE_WORD;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd_val;
   logic hreadyout, hresp, dmem_re, dmem_we, tk;
   logic [15:0] dmem_addr, ep;
   logic [7:0] dmem_wdata, dmem_rdata, io_rdata, fl;
   logic [6:0] k;
   logic [4:0] io_addr;
   logic [2:0] b;
   logic [1:0] cy;
   int bad_count = 0;
   int num_checks = 0;
   int pr[7] = '{26, 27, 4, 28, 29, 30, 31};
   logic [7:0] pv[7] = '{8'h20, 8'h01, 8'h77, 8'h00, 8'h02, 8'h00, 8'h03};
   always #2 hclk = ~hclk;
   bsls_exec u_dut (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
      .dmem_re(dmem_re), .dmem_we(dmem_we), .dmem_rdata(dmem_rdata), .io_addr(io_addr),
      .io_rdata(io_rdata)
   );
   bsls_dmem_model u_mem (
      .hclk(hclk), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_re(dmem_re),
      .dmem_we(dmem_we), .dmem_rdata(dmem_rdata), .io_addr(io_addr), .io_rdata(io_rdata)
   );
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   // single ahb transfer, waits bounded on hready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      int m;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= bsls_pkg::HSIZE_WORD;
      haddr <= {24'h0, a};
      @(posedge hclk);
      for (n = 0; n < 50 && hreadyout !== 1'b1; n++) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      for (m = 0; m < 50 && hreadyout !== 1'b1; m++) @(posedge hclk);
      rd_val = hrdata;
      if (n == 50 || m == 50) begin
         bad_count++;
         final_report();
      end
   endtask : xfer
   task automatic ck(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(rd_val, e)
   endtask : ck
   task automatic ex(input logic [31:0] i);
      xfer(1'b1, bsls_pkg::OFS_INSTR, i);
   endtask : ex
   task automatic pcst(input logic [15:0] p, input logic [2:0] s);
      ck(bsls_pkg::OFS_PC, {16'h0, p});
      ck(bsls_pkg::OFS_STATUS, {29'h0, s});
   endtask : pcst
   function automatic logic [7:0] g(input int n);
      return 8'h80 + 8'(4 * n);
   endfunction : g
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 5; i++) ck(8'(4 * i), 32'h0);
      ck(g(31), 32'h0);
      ck(8'h40, 32'h0);
      $display("test reset done");
      // all flag selects, both forms, both flag values, both offset signs
      for (int j = 0; j < 32; j++) begin
         k = j[0] ? 7'h7d : 7'h05;
         fl = j[4] ? 8'h01 << j[2:0] : ~(8'h01 << j[2:0]);
         if (j[2:0] == 3'h4) fl = j[4] ? 8'h04 : 8'hff;
         tk = j[4] ^ j[3];
         ep = tk ? 16'h0041 + {{9{k[6]}}, k} : 16'h0041;
         xfer(1'b1, bsls_pkg::OFS_FLAGS, {24'h0, fl});
         xfer(1'b1, bsls_pkg::OFS_PC, 32'h40);
         ex({16'h0, 5'h1e, j[3], k, j[2:0]});
         pcst(ep, {tk, tk, ~tk});
         ck(bsls_pkg::OFS_FLAGS, {24'h0, fl});
      end
      $display("test branch done");
      xfer(1'b1, g(5), 32'h08);
      for (int j = 0; j < 16; j++) begin
         b = j[3] ? {2'b00, ~j[1]} : {2'b01, j[1]};
         tk = j[1] == j[0];
         cy = tk ? 2'h2 + {1'b0, j[2]} : 2'h1;
         xfer(1'b1, bsls_pkg::OFS_CTRL, {31'h0, j[2]});
         xfer(1'b1, bsls_pkg::OFS_PC, 32'h0100);
         ex(j[3] ? {16'h0, 6'h26, j[0], 1'b1, 5'h03, b} : {16'h0, 6'h3f, j[0], 5'h05, 1'b0, b});
         pcst(16'h0100 + {14'h0, cy}, {tk, cy});
      end
      xfer(1'b1, bsls_pkg::OFS_CTRL, 32'h0);
      $display("test skip done");
      ex(32'h0000_ea07);
      ck(g(16), 32'ha7);
      ck(bsls_pkg::OFS_STATUS, 32'h1);
      ex(32'h0000_e51b);
      ex(32'h0000_2e30);
      ck(g(3), 32'ha7);
      ex(32'h0000_0108);
      ck(g(1), 32'h5b);
      $display("test move done");
      xfer(1'b1, bsls_pkg::OFS_FLAGS, 32'hff);
      for (int i = 0; i < 7; i++) xfer(1'b1, g(pr[i]), {24'h0, pv[i]});
      ex(32'h0000_924d);
      ck(g(26), 32'h21);
      `CHK(u_mem.mem[16'h0120], 8'h77)
      ex(32'h0000_906e);
      ck(g(6), 32'h77);
      ck(g(26), 32'h20);
      ex(32'h0000_907d);
      ck(g(7), 32'h77);
      ck(g(26), 32'h21);
      ex(32'h0000_930e);
      ck(g(26), 32'h20);
      `CHK(u_mem.mem[16'h0120], 8'ha7)
      ex(32'h0000_ae4f);
      ck(g(28), 32'h0);
      `CHK(u_mem.mem[16'h023f], 8'h77)
      ex(32'h0000_ac8f);
      ck(g(8), 32'h77);
      ex(32'h0000_8091);
      ck(g(9), 32'h3d);
      ex(32'h0000_90b2);
      ck(g(11), 32'hc3);
      ck(g(30), 32'hff);
      ex(32'h0455_90a0);
      ck(g(10), 32'h69);
      ck(bsls_pkg::OFS_STATUS, 32'h2);
      ck(bsls_pkg::OFS_FLAGS, 32'hff);
      ex(32'h0000_0000);
      ck(bsls_pkg::OFS_STATUS, 32'h9);
      ck(bsls_pkg::OFS_FLAGS, 32'hff);
      $display("test memory done");
      final_report();
   end
endmodule : tb_top
